// >>> core/crso_stream_out.sv
// completer request path output stream: source side of the user valid/ready stream
//
// Overview of operation
// - an 85-bit sideband bus describes the packet and means something only while valid is high.
// - end of packet is high only in the final beat of each packet.
// - a packet that fits in one beat has end of packet set in that first beat.
// - the keep bus has one bit per 32-bit dword, set when that dword of the beat is valid.
// - keep is contiguous from the first descriptor dword, full except in a short final beat.
// - keep bits 7:4 stay zero on a 128-bit bus and bits 7:2 stay zero on a 64-bit bus.
// - valid is high in every cycle with meaningful data on the bus and in no other.
// - once a packet starts, valid stays high with no idle cycle until its final beat.
// - a beat moves only in a cycle where valid and ready are both high.
// - with valid high and ready low the same beat is held and valid stays high.
// - data bits above the configured width (255:128 or 255:64) stay zero.
//
// structure: one output register stage sits between the internal request
// source and the user stream. keep and lane clearing are worked out from the
// source beat before it enters the stage, so every user side output comes
// straight from a flop. the source is asked for a new beat only when the
// stage is empty or its beat leaves in this cycle, which gives one beat per
// cycle of throughput without a skid buffer.
// limitation: the stage cannot make up beats; a source that pauses inside a
// packet leaves a hole in valid, which is reported on source_gap_o.
// the packet length output holds at the counter top instead of wrapping.
`timescale 1ns/1ns
`default_nettype none
module crso_stream_out #(
    parameter int BUS_WIDTH = crso_pkg::WIDTH_256
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    // internal request source
    input wire logic src_valid_i,
    input wire crso_pkg::crso_src_beat_type src_beat_i,
    output logic src_ready_o,
    // user side stream
    output logic req_out_valid_o,
    output logic [crso_pkg::DATA_BITS-1:0] req_out_data_o,
    output logic [crso_pkg::SIDEBAND_BITS-1:0] req_out_sideband_o,
    output logic [crso_pkg::KEEP_BITS-1:0] req_out_dword_keep_o,
    output logic req_out_end_of_packet_o,
    input wire logic req_out_ready_i,
    // status
    output logic pkt_done_o,
    output logic [crso_pkg::BEAT_CNT_BITS-1:0] pkt_beats_o,
    output logic source_gap_o
);
    // dwords carried by the configured bus
    localparam int BUS_DWORDS = BUS_WIDTH / crso_pkg::DWORD_BITS;
    // top of the beat counter, where counting stops
    localparam logic [crso_pkg::BEAT_CNT_BITS-1:0] CNT_MAX = '1;

    // output stage and packet tracking
    logic valid_q;
    logic valid_d;
    crso_pkg::crso_beat_type beat_q;
    crso_pkg::crso_beat_type beat_d;
    logic in_pkt_q;
    logic in_pkt_d;
    logic [crso_pkg::BEAT_CNT_BITS-1:0] beat_cnt_q;
    logic [crso_pkg::BEAT_CNT_BITS-1:0] beat_cnt_d;
    logic [crso_pkg::BEAT_CNT_BITS-1:0] pkt_beats_q;
    logic done_q;
    logic gap_q;
    logic gap_seen_q;

    // handshake terms
    logic accept;
    logic load;
    logic pkt_end;
    logic [crso_pkg::KEEP_BITS-1:0] keep_new;
    logic [crso_pkg::DATA_BITS-1:0] data_new;

    // a beat moves only when both sides agree
    assign accept = valid_q && req_out_ready_i;
    // the stage refills when empty or when its beat leaves this cycle
    assign src_ready_o = !valid_q || req_out_ready_i;
    assign load = src_valid_i && src_ready_o;
    // the final beat of a packet leaves in this cycle
    assign pkt_end = accept && beat_q.last;

    // keep and lane clearing for the incoming beat
    crso_keep_gen #(
        .BUS_DWORDS(BUS_DWORDS)
    ) u_keep (
        .dword_count_i(src_beat_i.dword_count),
        .last_i(src_beat_i.last),
        .data_i(src_beat_i.data),
        .keep_o(keep_new),
        .data_o(data_new)
    );

    // next beat: taken only when the stage may change, so a stalled beat stays put
    always_comb begin
        beat_d = beat_q;
        if (load) begin
            beat_d.data = data_new;
            beat_d.keep = keep_new;
            beat_d.sideband = src_beat_i.sideband;
            // the source marks the final beat, which may also be the first
            beat_d.last = src_beat_i.last;
        end
    end

    // valid follows the stage contents exactly
    always_comb begin
        valid_d = valid_q;
        if (load) begin
            valid_d = 1'b1;
        end else if (accept) begin
            valid_d = 1'b0;
        end
    end

    // valid register of the output stage
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
        end
    end

    // beat register; data outputs come straight from flops
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            beat_q.data <= crso_pkg::DATA_RST;
            beat_q.keep <= crso_pkg::KEEP_RST;
            beat_q.sideband <= crso_pkg::SIDEBAND_RST;
            beat_q.last <= 1'b0;
        end else begin
            beat_q <= beat_d;
        end
    end

    // packet tracking: inside a packet from its first accepted beat to its last
    always_comb begin
        in_pkt_d = in_pkt_q;
        beat_cnt_d = beat_cnt_q;
        if (accept) begin
            if (beat_q.last) begin
                // single-beat packets never enter the in-packet state
                in_pkt_d = 1'b0;
                beat_cnt_d = crso_pkg::BEAT_CNT_RST;
            end else begin
                in_pkt_d = 1'b1;
                // saturate rather than wrap on very long packets
                if (beat_cnt_q != CNT_MAX) begin
                    beat_cnt_d = beat_cnt_q + crso_pkg::BEAT_CNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            in_pkt_q <= 1'b0;
            beat_cnt_q <= crso_pkg::BEAT_CNT_RST;
        end else begin
            in_pkt_q <= in_pkt_d;
            beat_cnt_q <= beat_cnt_d;
        end
    end

    // packet completion pulse, one cycle after the final beat leaves
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= pkt_end;
        end
    end

    // length of the packet just finished; held at the top, a wrap would read as zero
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pkt_beats_q <= crso_pkg::BEAT_CNT_RST;
        end else if (pkt_end) begin
            if (beat_cnt_q == CNT_MAX) begin
                pkt_beats_q <= CNT_MAX;
            end else begin
                pkt_beats_q <= beat_cnt_q + crso_pkg::BEAT_CNT_ONE;
            end
        end
    end

    // gap watch: the stage cannot invent beats, so a source that stalls
    // mid-packet would break the no-gap promise; flag it once per packet
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            gap_q <= 1'b0;
        end else begin
            gap_q <= in_pkt_q && !valid_q && !gap_seen_q;
        end
    end

    // once flagged, stay quiet until the packet is over
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            gap_seen_q <= 1'b0;
        end else if (!in_pkt_q) begin
            gap_seen_q <= 1'b0;
        end else if (!valid_q) begin
            gap_seen_q <= 1'b1;
        end
    end

    // user side outputs
    assign req_out_valid_o = valid_q;
    assign req_out_data_o = beat_q.data;
    assign req_out_sideband_o = beat_q.sideband;
    assign req_out_dword_keep_o = beat_q.keep;
    assign req_out_end_of_packet_o = beat_q.last;

    // status outputs
    assign pkt_done_o = done_q;
    assign pkt_beats_o = pkt_beats_q;
    assign source_gap_o = gap_q;
endmodule : crso_stream_out
`default_nettype wire

// >>> core/crso_pkg.sv
// constants and beat types for the completer request output stream
package crso_pkg;
    // bus geometry
    localparam int DATA_BITS = 256;
    localparam int DWORD_BITS = 32;
    localparam int KEEP_BITS = DATA_BITS / DWORD_BITS;
    localparam int SIDEBAND_BITS = 85;
    localparam int COUNT_BITS = 4;
    localparam int BEAT_CNT_BITS = 10;
    // configured data widths that the core supports
    localparam int WIDTH_64 = 64;
    localparam int WIDTH_128 = 128;
    localparam int WIDTH_256 = 256;
    // reset values
    localparam logic [DATA_BITS-1:0] DATA_RST = '0;
    localparam logic [KEEP_BITS-1:0] KEEP_RST = 8'h00;
    localparam logic [SIDEBAND_BITS-1:0] SIDEBAND_RST = '0;
    localparam logic [COUNT_BITS-1:0] COUNT_NONE = 4'h0;
    localparam logic [BEAT_CNT_BITS-1:0] BEAT_CNT_RST = 10'h000;
    localparam logic [BEAT_CNT_BITS-1:0] BEAT_CNT_ONE = 10'h001;

    // one beat as handed over by the internal request source
    typedef struct packed {
        logic [SIDEBAND_BITS-1:0] sideband;
        logic [COUNT_BITS-1:0] dword_count;
        logic last;
        logic [DATA_BITS-1:0] data;
    } crso_src_beat_type;

    // one beat as presented to user logic
    typedef struct packed {
        logic [SIDEBAND_BITS-1:0] sideband;
        logic [KEEP_BITS-1:0] keep;
        logic last;
        logic [DATA_BITS-1:0] data;
    } crso_beat_type;
endpackage : crso_pkg

// >>> core/crso_keep_gen.sv
// per-dword keep mask and data lane clearing for one beat
`timescale 1ns/1ns
`default_nettype none
module crso_keep_gen #(
    parameter int BUS_DWORDS = crso_pkg::KEEP_BITS
) (
    input wire logic [crso_pkg::COUNT_BITS-1:0] dword_count_i,
    input wire logic last_i,
    input wire logic [crso_pkg::DATA_BITS-1:0] data_i,
    output logic [crso_pkg::KEEP_BITS-1:0] keep_o,
    output logic [crso_pkg::DATA_BITS-1:0] data_o
);
    // a zero count on a final beat is taken as a full beat
    logic partial;
    assign partial = last_i && (dword_count_i != crso_pkg::COUNT_NONE);

    // one lane per dword: lanes above the bus width are tied low
    for (genvar i = 0; i < crso_pkg::KEEP_BITS; i++) begin : g_lane
        if (i < BUS_DWORDS) begin : g_used
            // contiguous from dword 0, short only on a final beat
            assign keep_o[i] = !partial || (i < int'(dword_count_i));
            assign data_o[i*crso_pkg::DWORD_BITS +: crso_pkg::DWORD_BITS] =
                data_i[i*crso_pkg::DWORD_BITS +: crso_pkg::DWORD_BITS];
        end else begin : g_unused
            assign keep_o[i] = 1'b0;
            assign data_o[i*crso_pkg::DWORD_BITS +: crso_pkg::DWORD_BITS] = '0;
        end
    end
endmodule : crso_keep_gen
`default_nettype wire

// >>> testbench/crso_sink_model.sv
// user-side sink model: accepts beats, holding them off when asked
`timescale 1ns/1ns
`default_nettype none
module crso_sink_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic stall_i,
    output logic ready_o
);
    logic [1:0] cnt_q;
    // two cycles ready, two held off, so the source must wait mid-packet
    always_ff @(posedge clk_i) begin
        cnt_q <= nrst_i ? cnt_q + 2'h1 : 2'h0;
    end
    assign ready_o = !stall_i || cnt_q[1];
endmodule : crso_sink_model
`default_nettype wire

// >>> testbench/crso_stream_out_chk.sv
// port checker for the completer request output stream
`timescale 1ns/1ns
`default_nettype none
module crso_stream_out_chk #(
    parameter int BUS_WIDTH = 256
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic src_valid_i,
    input wire logic src_ready_o,
    input wire logic req_out_valid_o,
    input wire logic [255:0] req_out_data_o,
    input wire logic [84:0] req_out_sideband_o,
    input wire logic [7:0] req_out_dword_keep_o,
    input wire logic req_out_end_of_packet_o,
    input wire logic req_out_ready_i
);
    localparam int KD = BUS_WIDTH / 32;
    localparam logic [7:0] KFULL = 8'hff >> (8 - KD);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_stall; req_out_valid_o && !req_out_ready_i; endsequence
    sequence s_take; src_valid_i && src_ready_o; endsequence
    property p_hold; s_stall |=> req_out_valid_o && $stable(req_out_data_o); endproperty
    property p_side; s_stall |=> $stable(req_out_sideband_o) && $stable(req_out_dword_keep_o)
        && $stable(req_out_end_of_packet_o); endproperty
    property p_lat; s_take |=> req_out_valid_o; endproperty
    property p_idle; !src_valid_i && src_ready_o |=> !req_out_valid_o; endproperty
    property p_ready; src_ready_o == (!req_out_valid_o || req_out_ready_i); endproperty
    property p_full; req_out_valid_o && !req_out_end_of_packet_o |-> req_out_dword_keep_o == KFULL;
    endproperty
    property p_contig; req_out_valid_o |-> req_out_dword_keep_o != 8'h00
        && ((req_out_dword_keep_o + 8'h01) & req_out_dword_keep_o) == 8'h00; endproperty
    property p_khi; (req_out_dword_keep_o >> KD) == 8'h00; endproperty
    property p_dhi; (req_out_data_o >> BUS_WIDTH) == '0; endproperty
    a_hold: assert property (p_hold) else $error("stalled beat changed");
    a_side: assert property (p_side) else $error("qualifiers moved in stall");
    a_lat: assert property (p_lat) else $error("taken beat not shown");
    a_idle: assert property (p_idle) else $error("valid without a beat");
    a_ready: assert property (p_ready) else $error("source ready wrong");
    a_full: assert property (p_full) else $error("inner beat not full");
    a_contig: assert property (p_contig) else $error("keep not contiguous");
    a_khi: assert property (p_khi) else $error("keep high bits set");
    a_dhi: assert property (p_dhi) else $error("data high lanes set");
endmodule : crso_stream_out_chk
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking testbench for the completer request output stream
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int BW = crso_pkg::WIDTH_128;
    logic clk_i, nrst_i, src_valid_i, stall, src_ready_o, vld, eop, rdy, done, gap, vld64;
    crso_pkg::crso_src_beat_type src_beat_i;
    logic [255:0] dat, ld, dat64, ld64;
    logic [84:0] sb, ls;
    logic [7:0] keep, lk, keep64, lk64;
    logic [9:0] beats;
    int mismatches, check_count, nacc, neop, ngap;
    crso_stream_out #(.BUS_WIDTH(BW)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .src_valid_i(src_valid_i), .src_beat_i(src_beat_i), .src_ready_o(src_ready_o),
        .req_out_valid_o(vld), .req_out_data_o(dat), .req_out_sideband_o(sb),
        .req_out_dword_keep_o(keep), .req_out_end_of_packet_o(eop), .req_out_ready_i(rdy),
        .pkt_done_o(done), .pkt_beats_o(beats), .source_gap_o(gap));
    // same stimulus into a 64-bit build, so the narrow lane clearing is seen too
    crso_stream_out #(.BUS_WIDTH(crso_pkg::WIDTH_64)) dut64_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .src_valid_i(src_valid_i), .src_beat_i(src_beat_i), .src_ready_o(),
        .req_out_valid_o(vld64), .req_out_data_o(dat64), .req_out_sideband_o(),
        .req_out_dword_keep_o(keep64), .req_out_end_of_packet_o(), .req_out_ready_i(rdy),
        .pkt_done_o(), .pkt_beats_o(), .source_gap_o());
    crso_sink_model sink_u (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .ready_o(rdy));
    // tally accepted beats and gap pulses; keep the last beat for inspection
    always @(posedge clk_i) begin
        ngap <= ngap + int'(gap);
        if (vld && rdy) begin
            nacc <= nacc + 1;
            neop <= neop + int'(eop);
            lk <= keep;
            ld <= dat;
            ls <= sb;
        end
        if (vld64 && rdy) begin
            lk64 <= keep64;
            ld64 <= dat64;
        end
    end
    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    // send n beats, g idle source cycles after the first, then wait for the done pulse
    task automatic pkt(input int n, input logic [3:0] c, input logic s, input int g);
        int n0;
        int e0;
        int g0;
        int k;
        @(posedge clk_i);
        #2;
        n0 = nacc;
        e0 = neop;
        g0 = ngap;
        stall = s;
        for (int i = 0; i < n; i++) begin
            src_valid_i = 1;
            src_beat_i = {85'(i + 1), c, i == n - 1, {256{1'b1}}};
            do @(negedge clk_i); while (!src_ready_o);
            @(posedge clk_i);
            #2;
            if (i == 0 && n > 1 && g > 0) begin
                src_valid_i = 0;
                repeat (g) @(posedge clk_i);
                #2;
            end
        end
        src_valid_i = 0;
        for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk_i);
        check(32'(k < 200), 32'h0000_0001);
        check(32'(nacc - n0), 32'(n));
        check(32'(neop - e0), 32'h0000_0001);
        check(32'(ngap - g0), 32'(g > 0 && n > 1));
        check(beats, 10'(n));
        check(ld, {256{1'b1}} >> (256 - BW));
        check(ld64, {256{1'b1}} >> (256 - crso_pkg::WIDTH_64));
        check(ls, 85'(n));
    endtask : pkt
    task automatic t_reset_state;
        check({vld, eop, done, gap}, 4'h0);
        check(dat, '0);
        check(sb, '0);
        check(keep, 8'h00);
        check(beats, 10'h000);
        check(src_ready_o, 1'b1);
        $display("reset state done");
    endtask : t_reset_state
    task automatic t_single;
        pkt(1, 4'h3, 0, 0);
        check(lk, 8'h07);
        check(lk64, 8'h03);
        $display("single beat packet done");
    endtask : t_single
    task automatic t_stall;
        pkt(5, 4'h0, 1, 0);
        check(lk, 8'h0f);
        check(lk64, 8'h03);
        $display("stalled full packet done");
    endtask : t_stall
    task automatic t_tails;
        for (int c = 1; c <= 4; c++) begin
            pkt(3, 4'(c), c[0], 0);
            check(lk, 8'hff >> (8 - c));
            check(lk64, (8'hff >> (8 - c)) & 8'h03);
        end
        $display("short tail packets done");
    endtask : t_tails
    task automatic t_gap;
        pkt(2, 4'h2, 0, 2);
        check(lk, 8'h03);
        check(lk64, 8'h03);
        $display("paused source packet done");
    endtask : t_gap
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        nrst_i = 0;
        src_valid_i = 0;
        src_beat_i = '0;
        stall = 0;
        repeat (6) @(posedge clk_i);
        #2 nrst_i = 1;
        t_reset_state;
        t_single;
        t_stall;
        t_tails;
        t_gap;
        complete_run;
    end
    // about 50 cycles of traffic are expected; this is far beyond
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
endmodule : tb_top
bind crso_stream_out crso_stream_out_chk #(.BUS_WIDTH(BUS_WIDTH)) chk_u (.clk_i(clk_i),
    .nrst_i(nrst_i), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
    .req_out_valid_o(req_out_valid_o), .req_out_data_o(req_out_data_o),
    .req_out_sideband_o(req_out_sideband_o), .req_out_dword_keep_o(req_out_dword_keep_o),
    .req_out_end_of_packet_o(req_out_end_of_packet_o), .req_out_ready_i(req_out_ready_i));
`default_nettype wire
